/* File: shared/fsp_pkg.sv */
// Constants and types shared by both ends of the flash self-programming sequencer.
package fsp_pkg;
	localparam int unsigned ADDR_W         = 16;
	localparam int unsigned WORD_W         = 24;
	localparam int unsigned DATA_W         = 16;
	localparam int unsigned HIGH_W         = WORD_W - DATA_W;
	localparam int unsigned ROW_WORDS      = 64;
	localparam int unsigned ROW_BYTES      = 192;
	localparam int unsigned PAGE_ROWS      = 8;
	localparam int unsigned PAGE_WORDS     = ROW_WORDS * PAGE_ROWS;
	localparam int unsigned PAGE_BYTES     = 1536;
	localparam int unsigned BYTES_PER_WORD = ROW_BYTES / ROW_WORDS;
	localparam int unsigned ROW_SH         = $clog2(ROW_WORDS);
	localparam int unsigned PAGE_SH        = $clog2(PAGE_WORDS);
	localparam logic [7:0]  KEY_FIRST      = 8'h55;
	localparam logic [7:0]  KEY_SECOND     = 8'haa;
	localparam int unsigned CTL_GO_BIT     = 15;
	localparam int unsigned CTL_ERR_BIT    = 13;
	localparam int unsigned CTL_OP_LSB     = 0;
	localparam int unsigned CTL_OP_W       = 2;
	localparam logic [1:0]  OP_NONE        = 2'h0;
	localparam logic [1:0]  OP_WORD        = 2'h1;
	localparam logic [1:0]  OP_ROW         = 2'h2;
	localparam logic [1:0]  OP_ERASE       = 2'h3;
	localparam int unsigned CORE_PERIOD_PS = 5000;
	localparam int unsigned CORE_KHZ       = 1000000000 / CORE_PERIOD_PS;
	localparam int unsigned OSC_KHZ        = 7370;
	localparam int unsigned ROW_OSC_CYC    = 11064;
	localparam int unsigned WORD_OSC_CYC   = 1000;
	localparam int unsigned ERASE_OSC_CYC  = 20000;
	localparam int unsigned OSC_CNT_W      = 16;
	localparam int unsigned OSC_ACC_W      = 18;
	typedef enum logic [1:0] {FSP_K_TBL_LO, FSP_K_TBL_HI, FSP_K_KEY, FSP_K_CTL} fsp_kind_e;
endpackage

/* File: shared/fsp_if.sv */
// Connection between the processor core end and the flash sequencer end.
interface fsp_if;
	import fsp_pkg::*;
	logic              req;
	fsp_kind_e         kind;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic              stall;
	logic [DATA_W-1:0] ctl_rd;
	modport seq
	(
		input  req,
		input  kind,
		input  addr,
		input  wdata,
		output stall,
		output ctl_rd
	);
	modport core
	(
		output req,
		output kind,
		output addr,
		output wdata,
		input  stall,
		input  ctl_rd
	);
endinterface

/* File: core/fsp_core_host.sv */
// Processor core end: loads the holding buffers, unlocks and starts an operation.
module fsp_core_host
	import fsp_pkg::*;
(
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	fsp_if.core                    bus,
	input  wire logic              start_i,
	input  wire logic [1:0]        op_i,
	input  wire logic [ADDR_W-1:0] addr_i,
	input  wire logic              ld_valid_i,
	input  wire logic [WORD_W-1:0] ld_data_i,
	output logic                   ld_ready_o,
	output logic                   busy_o,
	output logic                   done_o,
	output logic                   err_o
);
	typedef enum logic [2:0] {H_IDLE, H_LOAD, H_LO, H_HI, H_KEY1, H_KEY2, H_CTL, H_WAIT} fsp_host_e;

	fsp_host_e         st_r;
	logic              req_r;
	fsp_kind_e         kind_r;
	logic [ADDR_W-1:0] addr_r;
	logic [DATA_W-1:0] wdata_r;
	logic [HIGH_W-1:0] high_r;
	logic [ROW_SH:0]   cnt_r;
	logic [1:0]        op_r;

	wire taken = req_r & ~bus.stall;
	wire finished = ~bus.stall & ~bus.ctl_rd[CTL_GO_BIT];
	wire [ADDR_W-1:0] row_base = {addr_i[ADDR_W-1:ROW_SH], {ROW_SH{1'b0}}};
	wire [DATA_W-1:0] ctl_word = (DATA_W'(1) << CTL_GO_BIT) | (DATA_W'(op_r) << CTL_OP_LSB);

	assign bus.req   = req_r;
	assign bus.kind  = kind_r;
	assign bus.addr  = addr_r;
	assign bus.wdata = wdata_r;

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st_r       <= H_IDLE;
			req_r      <= 1'b0;
			kind_r     <= FSP_K_TBL_LO;
			addr_r     <= '0;
			wdata_r    <= '0;
			high_r     <= '0;
			cnt_r      <= '0;
			op_r       <= OP_NONE;
			ld_ready_o <= 1'b0;
			busy_o     <= 1'b0;
			done_o     <= 1'b0;
			err_o      <= 1'b0;
		end
		else if (ce_i)
		begin
			done_o <= 1'b0;
			unique case (st_r)
				H_IDLE:
					if (start_i)
					begin
						busy_o <= 1'b1;
						op_r   <= op_i;
						addr_r <= (op_i == OP_ROW) ? row_base : addr_i;
						cnt_r  <= (op_i == OP_ROW) ? (ROW_SH+1)'(ROW_WORDS) : (ROW_SH+1)'(1);
						if (op_i == OP_ERASE)
						begin
							st_r    <= H_KEY1;
							req_r   <= 1'b1;
							kind_r  <= FSP_K_KEY;
							wdata_r <= DATA_W'(KEY_FIRST);
						end
						else
						begin
							st_r       <= H_LOAD;
							ld_ready_o <= 1'b1;
						end
					end
				H_LOAD:
					if (ld_valid_i)
					begin
						ld_ready_o <= 1'b0;
						high_r     <= ld_data_i[WORD_W-1:DATA_W];
						req_r      <= 1'b1;
						kind_r     <= FSP_K_TBL_LO;
						wdata_r    <= ld_data_i[DATA_W-1:0];
						st_r       <= H_LO;
					end
				H_LO:
					if (taken)
					begin
						kind_r  <= FSP_K_TBL_HI;
						wdata_r <= DATA_W'(high_r);
						st_r    <= H_HI;
					end
				H_HI:
					if (taken)
					begin
						cnt_r <= cnt_r - 1'b1;
						if (cnt_r == (ROW_SH+1)'(1))
						begin
							kind_r  <= FSP_K_KEY;
							wdata_r <= DATA_W'(KEY_FIRST);
							st_r    <= H_KEY1;
						end
						else
						begin
							req_r      <= 1'b0;
							addr_r     <= addr_r + 1'b1;
							ld_ready_o <= 1'b1;
							st_r       <= H_LOAD;
						end
					end
				H_KEY1:
					if (taken)
					begin
						wdata_r <= DATA_W'(KEY_SECOND);
						st_r    <= H_KEY2;
					end
				H_KEY2:
					if (taken)
					begin
						kind_r  <= FSP_K_CTL;
						wdata_r <= ctl_word;
						st_r    <= H_CTL;
					end
				H_CTL:
					if (taken)
					begin
						req_r <= 1'b0;
						st_r  <= H_WAIT;
					end
				H_WAIT:
					if (finished)
					begin
						busy_o <= 1'b0;
						done_o <= 1'b1;
						err_o  <= bus.ctl_rd[CTL_ERR_BIT];
						st_r   <= H_IDLE;
					end
			endcase
		end
	end
endmodule

/* File: core/fsp_seq.sv */
// Flash self-programming sequencer: holding buffers, unlock, timed program and erase.
// Functional notes
// - Array rows hold 64 words, 192 bytes.
// - Erase works on eight-row, 512-word pages.
// - Program a whole row or one word.
// - Pages and rows align from memory start.
// - Holding buffers hold 64 instruction words.
// - Core fills buffers sequentially before programming.
// - Buffered words share one 64-word group.
// - Row load needs 64 low, 64 high writes.
// - Each table write takes two cycles.
// - Core starts one programming cycle per row.
// - Core stays stalled until operation completes.
// - Go bit starts operation, clears when done.
// - Row write lasts 11064 oscillator cycles.
// - Core writes 0x55 then 0xAA first.
// - Control register selects operation and starts it.
module fsp_seq
	import fsp_pkg::*;
#(
	parameter int unsigned ROW_OSC   = ROW_OSC_CYC,
	parameter int unsigned WORD_OSC  = WORD_OSC_CYC,
	parameter int unsigned ERASE_OSC = ERASE_OSC_CYC,
	parameter int unsigned OSC_RATE  = OSC_KHZ
)
(
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	input  wire logic              ce_i,
	fsp_if.seq                     bus,
	output logic                   array_we_o,
	output logic                   array_erase_o,
	output logic [ADDR_W-1:0]      array_addr_o,
	output logic [WORD_W-1:0]      array_data_o,
	output logic                   op_done_o
);
	typedef enum logic {FSP_IDLE, FSP_RUN} fsp_state_e;
	typedef enum logic [1:0] {FSP_LOCKED, FSP_HALF, FSP_OPEN} fsp_lock_e;

	// The oscillator is modelled as a fractional divider of the core clock.
	localparam logic [OSC_ACC_W-1:0] OSC_INC = OSC_ACC_W'(OSC_RATE);
	localparam logic [OSC_ACC_W-1:0] OSC_MOD = OSC_ACC_W'(CORE_KHZ);

	fsp_state_e           state_r;
	fsp_state_e           state_nxt;
	fsp_lock_e            lock_r;
	fsp_lock_e            lock_nxt;
	logic                 stall_r;
	logic                 stall_nxt;
	logic                 go_r;
	logic                 go_nxt;
	logic                 err_r;
	logic                 err_nxt;
	logic [1:0]           op_r;
	logic [1:0]           op_nxt;
	logic [1:0]           run_op_r;
	logic [ADDR_W-1:0]    tp_r;
	logic [OSC_ACC_W-1:0] acc_r;
	logic [OSC_ACC_W-1:0] acc_nxt;
	logic [OSC_CNT_W-1:0] osc_cnt_r;
	logic [OSC_CNT_W-1:0] osc_cnt_nxt;
	logic [OSC_CNT_W-1:0] dur_r;
	logic [ROW_SH:0]      si_r;
	logic [WORD_W-1:0]    hbuf [ROW_WORDS];

	wire running = (state_r == FSP_RUN);
	wire take    = bus.req & ~stall_r;
	wire take_lo  = take && (bus.kind == FSP_K_TBL_LO);
	wire take_hi  = take && (bus.kind == FSP_K_TBL_HI);
	wire take_key = take && (bus.kind == FSP_K_KEY);
	wire take_ctl = take && (bus.kind == FSP_K_CTL);
	wire key_first  = take_key && (bus.wdata[7:0] == KEY_FIRST);
	wire key_second = take_key && (bus.wdata[7:0] == KEY_SECOND) && (lock_r == FSP_HALF);
	wire [1:0] op_sel = bus.wdata[CTL_OP_LSB +: CTL_OP_W];
	wire go_req = take_ctl && bus.wdata[CTL_GO_BIT];
	wire go_ok  = go_req && (lock_r == FSP_OPEN) && (op_sel != OP_NONE) && !running;
	wire go_bad = go_req && !go_ok;

	// Buffer slot follows the low address bits, so a row's words land in order.
	wire [ROW_SH-1:0] buf_idx = bus.addr[ROW_SH-1:0];

	wire [OSC_CNT_W-1:0] dur_sel =
		(op_sel == OP_ROW)   ? OSC_CNT_W'(ROW_OSC) :
		(op_sel == OP_ERASE) ? OSC_CNT_W'(ERASE_OSC) :
		OSC_CNT_W'(WORD_OSC);

	wire [OSC_ACC_W-1:0] acc_sum = acc_r + OSC_INC;
	wire                 osc_tick = running && (acc_sum >= OSC_MOD);
	wire                 finish = osc_tick && (osc_cnt_r == dur_r - 1'b1);

	wire [ROW_SH:0] n_emit = (run_op_r == OP_ROW) ? (ROW_SH+1)'(ROW_WORDS) : (ROW_SH+1)'(1);
	wire            emit   = running && (si_r < n_emit);
	wire            we_nxt = emit && (run_op_r != OP_ERASE);
	wire            er_nxt = emit && (run_op_r == OP_ERASE);

	wire [ROW_SH-1:0] rd_idx = (run_op_r == OP_ROW) ? si_r[ROW_SH-1:0] : tp_r[ROW_SH-1:0];
	wire [ADDR_W-1:0] row_addr  = {tp_r[ADDR_W-1:ROW_SH], si_r[ROW_SH-1:0]};
	wire [ADDR_W-1:0] page_addr = {tp_r[ADDR_W-1:PAGE_SH], {PAGE_SH{1'b0}}};
	wire [ADDR_W-1:0] addr_nxt =
		(run_op_r == OP_ROW)   ? row_addr :
		(run_op_r == OP_ERASE) ? page_addr :
		tp_r;

	assign bus.stall  = stall_r;
	assign bus.ctl_rd = (DATA_W'(go_r) << CTL_GO_BIT) | (DATA_W'(err_r) << CTL_ERR_BIT)
		| (DATA_W'(op_r) << CTL_OP_LSB);

	// Only the full two-step sequence opens the lock, and any other access shuts it.
	assign lock_nxt =
		!take      ? lock_r :
		key_first  ? FSP_HALF :
		key_second ? FSP_OPEN :
		FSP_LOCKED;

	assign state_nxt = go_ok ? FSP_RUN : finish ? FSP_IDLE : state_r;

	// A table write holds the core off for one cycle, so each takes two cycles.
	assign stall_nxt = go_ok || (running && !finish) || take_lo || take_hi;

	assign go_nxt = go_ok ? 1'b1 : finish ? 1'b0 : go_r;

	// A refused start raises the error flag; a write in the same cycle cannot clear it.
	assign err_nxt = go_bad ? 1'b1 : take_ctl ? 1'b0 : err_r;

	assign op_nxt = take_ctl ? op_sel : op_r;

	assign acc_nxt = !running ? '0 : (acc_sum >= OSC_MOD) ? acc_sum - OSC_MOD : acc_sum;

	assign osc_cnt_nxt = !running ? '0 : osc_tick ? osc_cnt_r + 1'b1 : osc_cnt_r;

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state_r   <= FSP_IDLE;
			lock_r    <= FSP_LOCKED;
			stall_r   <= 1'b0;
			go_r      <= 1'b0;
			err_r     <= 1'b0;
			op_r      <= OP_NONE;
			acc_r     <= '0;
			osc_cnt_r <= '0;
		end
		else if (ce_i)
		begin
			state_r   <= state_nxt;
			lock_r    <= lock_nxt;
			stall_r   <= stall_nxt;
			go_r      <= go_nxt;
			err_r     <= err_nxt;
			op_r      <= op_nxt;
			acc_r     <= acc_nxt;
			osc_cnt_r <= osc_cnt_nxt;
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			run_op_r <= OP_NONE;
			dur_r    <= '0;
			si_r     <= '0;
			tp_r     <= '0;
		end
		else if (ce_i)
		begin
			if (go_ok)
			begin
				run_op_r <= op_sel;
				dur_r    <= dur_sel;
				si_r     <= '0;
			end
			else if (emit)
			begin
				si_r <= si_r + 1'b1;
			end
			// The control write carries the target too, so an erase needs no table write first.
			if (take_lo || take_hi || take_ctl)
			begin
				tp_r <= bus.addr;
			end
		end
	end

	// Buffer words change only under table writes, never when a program runs.
	always_ff @(posedge core_clk_i)
	begin
		if (ce_i && take_lo)
		begin
			hbuf[buf_idx][DATA_W-1:0] <= bus.wdata;
		end
		if (ce_i && take_hi)
		begin
			hbuf[buf_idx][WORD_W-1:DATA_W] <= bus.wdata[HIGH_W-1:0];
		end
	end

	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			array_we_o    <= 1'b0;
			array_erase_o <= 1'b0;
			array_addr_o  <= '0;
			array_data_o  <= '0;
			op_done_o     <= 1'b0;
		end
		else if (ce_i)
		begin
			array_we_o    <= we_nxt;
			array_erase_o <= er_nxt;
			array_addr_o  <= addr_nxt;
			array_data_o  <= hbuf[rd_idx];
			op_done_o     <= finish;
		end
	end
endmodule

/* File: bench/fsp_seq_properties.sv */
// Interface assertions for the flash self-programming sequencer.
module fsp_seq_properties
	import fsp_pkg::*;
#(
	parameter int unsigned ROW_OSC  = ROW_OSC_CYC,
	parameter int unsigned OSC_RATE = OSC_KHZ
)
(
	input  wire logic              core_clk_i,
	input  wire logic              rst_i,
	input  wire logic              req,
	input  wire fsp_kind_e         kind,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [DATA_W-1:0] wdata,
	input  wire logic              stall,
	input  wire logic [DATA_W-1:0] ctl_rd
);
	timeunit 1ns;
	timeprecision 100ps;
	// One oscillator tick of slack each side, since the tick phase at start is unknown.
	localparam int GO_MIN = (ROW_OSC - 1) * CORE_KHZ / OSC_RATE;
	localparam int GO_MAX = (ROW_OSC + 1) * CORE_KHZ / OSC_RATE + 2;
	logic [1:0]  lock_r;
	logic [1:0]  lock_nxt;
	logic [15:0] go_cnt_r;
	wire         go    = ctl_rd[CTL_GO_BIT];
	wire         taken = req && !stall;
	wire         key1  = kind == FSP_K_KEY && wdata[7:0] == KEY_FIRST;
	wire         key2  = kind == FSP_K_KEY && wdata[7:0] == KEY_SECOND && lock_r == 2'h1;
	wire         ctl_t = taken && kind == FSP_K_CTL;
	wire         tbl_t = taken && (kind == FSP_K_TBL_LO || kind == FSP_K_TBL_HI);
	wire         go_ok = ctl_t && wdata[CTL_GO_BIT] && lock_r == 2'h2 && wdata[1:0] != OP_NONE;
	assign lock_nxt = !taken ? lock_r : key1 ? 2'h1 : key2 ? 2'h2 : 2'h0;
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			lock_r   <= 2'h0;
			go_cnt_r <= 16'h0;
		end
		else
		begin
			lock_r   <= lock_nxt;
			go_cnt_r <= go ? go_cnt_r + 16'h1 : 16'h0;
		end
	end
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	a_tbl_stall_one: assert property (tbl_t |=> stall ##1 !stall)
		else $error("table write stall is not one cycle");
	a_go_starts: assert property (go_ok |=> go && stall)
		else $error("unlocked start did not set go");
	a_go_holds: assert property (go |-> stall)
		else $error("core released while go set");
	a_go_time: assert property ($fell(go) |-> go_cnt_r >= GO_MIN && go_cnt_r <= GO_MAX)
		else $error("operation length out of range");
	a_go_release: assert property ($fell(go) |-> !stall)
		else $error("stall outlived go");
	a_idle_free: assert property (!go && !$past(tbl_t) |-> !stall)
		else $error("stall while idle");
	a_op_kept: assert property (ctl_t |=> ctl_rd[1:0] == $past(wdata[1:0]))
		else $error("op field not stored");
	a_err_clear: assert property (ctl_t && !wdata[CTL_GO_BIT] || go_ok |=> !ctl_rd[CTL_ERR_BIT])
		else $error("error bit not cleared");
endmodule

/* File: bench/flash_self_program_sequencer_tb.sv */
// Bench: host and sequencer joined, plus a bare sequencer driven by hand for refusals.
module flash_self_program_sequencer_tb
	import fsp_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned FAST = 4;
	logic              core_clk_i, rst_i, ce_i, start_i, ld_valid_i;
	logic [1:0]        op_i;
	logic [ADDR_W-1:0] addr_i, array_addr_o, a;
	logic [WORD_W-1:0] ld_data_i, array_data_o;
	logic              ld_ready_o, busy_o, done_o, err_o, array_we_o, array_erase_o, op_done_o;
	logic [WORD_W-1:0] wq[$], w[64];
	logic [ADDR_W-1:0] aq[$], eq[$];
	int                n_mismatch, tests_run, n_done, i, j;
	fsp_if bus ();
	fsp_if bus_b ();
	fsp_core_host u_fsp_core_host (.core_clk_i, .rst_i, .ce_i, .bus(bus), .start_i, .op_i, .addr_i,
		.ld_valid_i, .ld_data_i, .ld_ready_o, .busy_o, .done_o, .err_o);
	fsp_seq #(.ROW_OSC(FAST), .WORD_OSC(FAST), .ERASE_OSC(FAST)) u_fsp_seq (.core_clk_i, .rst_i, .ce_i,
		.bus(bus), .array_we_o, .array_erase_o, .array_addr_o, .array_data_o, .op_done_o);
	fsp_seq #(.ROW_OSC(FAST), .WORD_OSC(FAST), .ERASE_OSC(FAST)) u_fsp_seq_b (.core_clk_i, .rst_i, .ce_i,
		.bus(bus_b), .array_we_o(), .array_erase_o(), .array_addr_o(), .array_data_o(), .op_done_o());
	fsp_seq_properties #(.ROW_OSC(FAST), .OSC_RATE(OSC_KHZ)) u_fsp_seq_properties (.core_clk_i, .rst_i,
		.req(bus.req), .kind(bus.kind), .addr(bus.addr), .wdata(bus.wdata), .stall(bus.stall), .ctl_rd(bus.ctl_rd));
	initial
	begin
		core_clk_i = 1'h0;
		forever #2.5 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i)
	begin
		if (array_we_o === 1'h1)
		begin
			aq.push_back(array_addr_o);
			wq.push_back(array_data_o);
		end
		if (array_erase_o === 1'h1)
			eq.push_back(array_addr_o);
		if (op_done_o === 1'h1)
			n_done++;
	end
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wait_hi(ref logic s);
		int g;
		g = 0;
		do
		begin
			@(posedge core_clk_i);
			g++;
		end
		while (s !== 1'h1 && g < 3000);
		check("handshake wait", g < 3000, 1);
	endtask
	task automatic run_op(logic [1:0] op, logic [ADDR_W-1:0] ad, int n);
		aq.delete();
		wq.delete();
		eq.delete();
		n_done = 0;
		@(posedge core_clk_i);
		#1 start_i = 1'h1;
		op_i = op;
		addr_i = ad;
		@(posedge core_clk_i);
		#1 start_i = 1'h0;
		check("busy", busy_o, 1);
		for (int k = 0; k < n; k++)
		begin
			w[k] = WORD_W'($urandom);
			ld_data_i = w[k];
			ld_valid_i = 1'h1;
			wait_hi(ld_ready_o);
			#1;
		end
		// Valid stays up between words, so it is lowered only once after the last one.
		ld_valid_i = 1'h0;
		wait_hi(done_o);
		#1 check("err", err_o, 0);
		check("busy after done", busy_o, 0);
		check("go after done", bus.ctl_rd[CTL_GO_BIT], 0);
		check("done pulses", n_done, 1);
	endtask
	task automatic b_req(fsp_kind_e k, logic [15:0] d);
		int g;
		@(posedge core_clk_i);
		#1 bus_b.req = 1'h1;
		bus_b.kind = k;
		bus_b.wdata = d;
		g = 0;
		do
		begin
			@(posedge core_clk_i);
			g++;
		end
		while (bus_b.stall !== 1'h0 && g < 3000);
		#1 bus_b.req = 1'h0;
		// A released bus must not keep looking valid.
		bus_b.wdata = ~d;
	endtask
	task automatic b_case(int nk, logic [7:0] k0, logic [7:0] k1, logic [15:0] c, logic go_e, logic err_e);
		if (nk > 0)
			b_req(FSP_K_KEY, {8'h0, k0});
		if (nk > 1)
			b_req(FSP_K_KEY, {8'h0, k1});
		b_req(FSP_K_CTL, c);
		check("go", bus_b.ctl_rd[CTL_GO_BIT], go_e);
		check("err", bus_b.ctl_rd[CTL_ERR_BIT], err_e);
		check("op", bus_b.ctl_rd[1:0], c[1:0]);
	endtask
	initial
	begin
		#60us;
		n_mismatch++;
		tally_and_finish();
	end
	initial
	begin
		rst_i = 1'h1;
		ce_i = 1'h1;
		{start_i, ld_valid_i, op_i, addr_i, ld_data_i} = '0;
		bus_b.req = 1'h0;
		bus_b.kind = FSP_K_KEY;
		bus_b.addr = '0;
		bus_b.wdata = '0;
		void'($urandom(32'hf6cf));
		repeat (8) @(posedge core_clk_i);
		#1 rst_i = 1'h0;
		for (i = 0; i < 3; i++)
		begin
			a = (i == 0) ? 16'h0 : (i == 1) ? 16'hffc0 : ADDR_W'($urandom);
			a[5:0] = 6'h0;
			run_op(OP_ROW, a, ROW_WORDS);
			check("row writes", aq.size(), ROW_WORDS);
			for (j = 0; j < aq.size(); j++)
			begin
				check("row addr", aq[j], a + j);
				check("row data", wq[j], w[j]);
			end
		end
		a = ADDR_W'($urandom);
		run_op(OP_WORD, a, 1);
		check("word writes", aq.size(), 1);
		check("word addr", aq[0], a);
		check("word data", wq[0], w[0]);
		a = ADDR_W'($urandom);
		run_op(OP_ERASE, a, 0);
		check("erase pulses", eq.size(), 1);
		check("erase base", eq[0], (a >> PAGE_SH) << PAGE_SH);
		b_case(0, 8'h0, 8'h0, 16'h8002, 1'h0, 1'h1);
		b_case(2, 8'haa, 8'h55, 16'h8002, 1'h0, 1'h1);
		b_case(2, 8'h55, 8'haa, 16'h8000, 1'h0, 1'h1);
		b_case(2, 8'h55, 8'haa, 16'h0002, 1'h0, 1'h0);
		b_case(2, 8'h55, 8'haa, 16'h8003, 1'h1, 1'h0);
		check("stalled", bus_b.stall, 1);
		for (i = 0; i < 3000 && bus_b.ctl_rd[CTL_GO_BIT] !== 1'h0; i++)
			@(posedge core_clk_i);
		#1 check("go self clear", bus_b.ctl_rd[CTL_GO_BIT], 0);
		check("stall freed", bus_b.stall, 0);
		tally_and_finish();
	end
endmodule
